// file: bench/vac_chargen_asserts.sv
// Port-level checks of the attribute and dot stage
`timescale 1ns/10ps
`include "vac_defines.vh"
module vac_chk (
  input wire clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire char_load,
  input wire [7:0] char_byte,
  input wire [7:0] char_attr,
  input wire cursor_here,
  input wire disp_active,
  input wire line_start,
  input wire frame_start,
  input wire video_out,
  input wire half_intensity_out_n
);
  reg [7:0] vcr_q, scr_q, l0_q, l1_q;
  reg skip_q;
  wire [7:0] at;
  wire take;
  wire plain;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Shadows only the registers that steer attributes
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      vcr_q <= `VAC_RST_VCR;
      scr_q <= `VAC_RST_SCR;
      l0_q <= `VAC_RST_LATCH;
      l1_q <= `VAC_RST_LATCH;
      skip_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `VAC_OFF_VIDEO_CTRL) vcr_q <= reg_wdata;
      if (reg_wr && reg_addr == `VAC_OFF_SYS_CTRL) scr_q <= reg_wdata;
      if (reg_wr && reg_addr == `VAC_OFF_LATCH_ZERO) l0_q <= reg_wdata;
      if (reg_wr && reg_addr == `VAC_OFF_LATCH_ONE) l1_q <= reg_wdata;
      // Load after a wide cell is ignored, so no dots of its own
      if (line_start) skip_q <= 1'b0;
      else if (char_load) skip_q <= !skip_q && !at[`VAC_AT_DWIDTH];
    end
  end
  assign at = (vcr_q[4] && scr_q[4]) ? char_attr :
              (char_byte[7] ? l1_q : l0_q);
  assign take = char_load && !line_start && !skip_q && disp_active;
  assign plain = take && !cursor_here && at[`VAC_AT_BLINK] &&
                 at[`VAC_AT_UNDERLINE] && at[`VAC_AT_GRAPHICS] && !vcr_q[1];
  a_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_latch_zero:
    assert property (reg_rd && reg_addr == `VAC_OFF_LATCH_ZERO
      |=> reg_rdata == l0_q) else $error("latch zero read back wrong");
  a_latch_one:
    assert property (reg_rd && reg_addr == `VAC_OFF_LATCH_ONE
      |=> reg_rdata == l1_q) else $error("latch one read back wrong");
  a_half_pin_off:
    assert property (scr_q[6] && $past(scr_q[6]) |-> half_intensity_out_n)
    else $error("half pin low while pin used as clock");
  a_half_pin_low:
    assert property (take && !scr_q[6] && !at[`VAC_AT_HALF] &&
      at[`VAC_AT_BLANK] && at[`VAC_AT_DWIDTH] |-> ##4 !half_intensity_out_n)
    else $error("half pin high on dimmed cell");
  a_first_col:
    assert property (plain && at[`VAC_AT_REVERSE] |-> ##2 !video_out)
    else $error("first cell column lit");
  a_reverse_col:
    assert property (plain && !at[`VAC_AT_REVERSE] && at[`VAC_AT_BLANK]
      |-> ##2 video_out) else $error("reversed cell border not lit");
  a_blank_cell:
    assert property (plain && at[`VAC_AT_REVERSE] && !at[`VAC_AT_BLANK] &&
      at[`VAC_AT_DHEIGHT] |-> ##2 (!video_out) [*8])
    else $error("blanked cell shows dots");
endmodule
bind vac_chargen vac_chk u_chk (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .char_load(char_load),
  .char_byte(char_byte), .char_attr(char_attr), .cursor_here(cursor_here),
  .disp_active(disp_active), .line_start(line_start),
  .frame_start(frame_start), .video_out(video_out),
  .half_intensity_out_n(half_intensity_out_n));

// file: bench/vac_monitor.sv
// Screen model that counts lit and dimmed dots
`timescale 1ns/10ps
module vac_monitor (
  input wire clk,
  input wire reset,
  input wire video_out,
  input wire half_intensity_out_n,
  output int lit_cnt,
  output int half_cnt
);
  // Unknown levels are not counted, so they pass as dark and as undimmed
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      lit_cnt <= 0;
      half_cnt <= 0;
    end else begin
      if (video_out === 1'b1) lit_cnt <= lit_cnt + 1;
      if (half_intensity_out_n === 1'b0) half_cnt <= half_cnt + 1;
    end
  end
endmodule

// file: bench/video_attribute_chargen_test.sv
// Self-checking bench for the attribute and glyph stage
`timescale 1ns/10ps
`include "vac_defines.vh"
module video_attribute_chargen_test;
  logic clk, reset, reg_wr, reg_rd, char_load, cursor_here;
  logic disp_active, line_start, frame_start, video_out, half_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, char_byte, char_attr, d, g;
  int lit_cnt, half_cnt, b_lit, b_half, error_cnt, checks;
  vac_chargen dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .char_load(char_load), .char_byte(char_byte),
    .char_attr(char_attr), .cursor_here(cursor_here),
    .disp_active(disp_active), .line_start(line_start),
    .frame_start(frame_start), .video_out(video_out),
    .half_intensity_out_n(half_n));
  vac_monitor mon (.clk(clk), .reset(reset), .video_out(video_out),
    .half_intensity_out_n(half_n), .lit_cnt(lit_cnt), .half_cnt(half_cnt));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // One frame start, one line, n cells spaced one cell width apart
  task run_line(input int n, input logic [7:0] b, input logic [7:0] at,
                input bit rnd);
    b_lit = lit_cnt;
    b_half = half_cnt;
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      char_load <= 1'b1;
      char_byte <= rnd ? 8'($urandom) : b;
      char_attr <= rnd ? 8'($urandom) : at;
      cursor_here <= rnd ? 1'($urandom) : 1'b0;
      disp_active <= rnd ? 1'($urandom) : 1'b1;
      @(posedge clk);
      char_load <= 1'b0;
      repeat (8) @(posedge clk);
    end
    // Close the line so no dots trail into the next test
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_sim;
  end
  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, char_load, cursor_here, disp_active} = 5'h00;
    {line_start, frame_start, reg_addr} = 6'h00;
    {reg_wdata, char_byte, char_attr} = 24'h0000_00;
    void'($urandom(40));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(`VAC_OFF_LATCH_ZERO, d); check(d, 16'h00ff);
    rd(`VAC_OFF_LATCH_ONE, d); check(d, 16'h00ff);
    rd(4'hE, d); check(d, 16'h0000);
    $display("test reset values done");
    g = 8'($urandom);
    wr(`VAC_OFF_LATCH_ZERO, g);
    wr(`VAC_OFF_LATCH_ONE, ~g);
    rd(`VAC_OFF_LATCH_ZERO, d); check(d, g);
    rd(`VAC_OFF_LATCH_ONE, d); check(d, {8'h00, ~g});
    $display("test latches done");
    for (int c = 0; c < 128; c++) begin
      for (int r = 0; r < 11; r++) begin
        wr(`VAC_OFF_GLYPH_CODE, 8'(c));
        wr(`VAC_OFF_GLYPH_ROW, 8'(r));
        wr(`VAC_OFF_GLYPH_DATA, 8'($urandom) & 8'h7f);
      end
    end
    rd(`VAC_OFF_GLYPH_DATA, d);
    g = d;
    wr(`VAC_OFF_GLYPH_DATA, ~g & 8'h7f);
    rd(`VAC_OFF_GLYPH_DATA, d); check(d, ~g & 8'h7f);
    $display("test glyph store done");
    wr(`VAC_OFF_GLYPH_CODE, 8'h3a);
    wr(`VAC_OFF_GLYPH_ROW, 8'h00);
    wr(`VAC_OFF_GLYPH_DATA, 8'h7f);
    wr(`VAC_OFF_LATCH_ZERO, 8'hbf);
    run_line(12, 8'h3a, 8'hff, 0);
    check(16'(lit_cnt - b_lit), 16'h0000);
    $display("test blank done");
    wr(`VAC_OFF_LATCH_ZERO, 8'hff);
    run_line(12, 8'h3a, 8'hff, 0);
    check(16'(lit_cnt - b_lit), 16'h0054);
    wr(`VAC_OFF_LATCH_ZERO, 8'hef);
    run_line(2, 8'h3a, 8'hff, 0);
    check(16'(lit_cnt - b_lit), 16'h000e);
    wr(`VAC_OFF_UNDERLINE, 8'h12);
    wr(`VAC_OFF_LATCH_ZERO, 8'h9f);
    run_line(4, 8'h3a, 8'hff, 0);
    check(16'(lit_cnt - b_lit), 16'h0024);
    wr(`VAC_OFF_UNDERLINE, `VAC_RST_UNDERLINE);
    $display("test glyph cells done");
    wr(`VAC_OFF_LATCH_ZERO, 8'hfd);
    wr(`VAC_OFF_LATCH_ONE, 8'hff);
    run_line(8, 8'h41, 8'hff, 0);
    check(16'(half_cnt - b_half), 16'h0048);
    run_line(8, 8'hc1, 8'hff, 0);
    check(16'(half_cnt - b_half), 16'h0000);
    wr(`VAC_OFF_SYS_CTRL, 8'h40);
    run_line(8, 8'h41, 8'hff, 0);
    check(16'(half_cnt - b_half), 16'h0000);
    $display("test half intensity done");
    wr(`VAC_OFF_LATCH_ZERO, 8'hff);
    wr(`VAC_OFF_VIDEO_CTRL, 8'h10);
    wr(`VAC_OFF_SYS_CTRL, 8'h10);
    run_line(10, 8'h3a, 8'hbf, 0);
    check(16'(lit_cnt - b_lit), 16'h0000);
    wr(`VAC_OFF_SYS_CTRL, 8'h00);
    wr(`VAC_OFF_LATCH_ZERO, 8'hbf);
    run_line(10, 8'h3a, 8'hff, 0);
    check(16'(lit_cnt - b_lit), 16'h0000);
    $display("test attribute source done");
    for (int k = 0; k < 6; k++) begin
      wr(`VAC_OFF_VIDEO_CTRL, 8'($urandom) & 8'h13);
      wr(`VAC_OFF_SYS_CTRL, 8'($urandom) & 8'h50);
      wr(`VAC_OFF_LATCH_ZERO, 8'($urandom));
      wr(`VAC_OFF_LATCH_ONE, 8'($urandom));
      run_line(30, 8'h00, 8'h00, 1);
    end
    $display("test random cells done");
    end_sim;
  end
endmodule

// file: inc/vac_defines.vh
// Register map, field positions and reset values of the attribute stage
`ifndef VAC_DEFINES_VH
`define VAC_DEFINES_VH

`define VAC_AW 4
`define VAC_OFF_VIDEO_CTRL 4'h0
`define VAC_OFF_SYS_CTRL 4'h1
`define VAC_OFF_LATCH_ZERO 4'h2
`define VAC_OFF_LATCH_ONE 4'h3
`define VAC_OFF_CELL_HEIGHT 4'h4
`define VAC_OFF_CELL_WIDTH 4'h5
`define VAC_OFF_UNDERLINE 4'h6
`define VAC_OFF_CURSOR 4'h7
`define VAC_OFF_BLINK 4'h8
`define VAC_OFF_GFX_ROWS 4'h9
`define VAC_OFF_GLYPH_CODE 4'hA
`define VAC_OFF_GLYPH_ROW 4'hB
`define VAC_OFF_GLYPH_DATA 4'hC
`define VAC_OFF_STATUS 4'hD

// Video control bits
`define VAC_VCR_BLINK_FIELD 0
`define VAC_VCR_SCREEN_REV 1
`define VAC_VCR_EXT_ATTR 4
// System control bits
`define VAC_SCR_BUS16 4
`define VAC_SCR_PIN_CLOCK 6

// Attribute bit positions, each active when zero
`define VAC_AT_REVERSE 0
`define VAC_AT_HALF 1
`define VAC_AT_BLINK 2
`define VAC_AT_DHEIGHT 3
`define VAC_AT_DWIDTH 4
`define VAC_AT_UNDERLINE 5
`define VAC_AT_BLANK 6
`define VAC_AT_GRAPHICS 7

// Reset values
`define VAC_RST_VCR 8'h00
`define VAC_RST_SCR 8'h00
`define VAC_RST_LATCH 8'hFF
`define VAC_RST_CELL_HEIGHT 4'hB
`define VAC_RST_CELL_WIDTH 4'h8
`define VAC_RST_UNDERLINE 8'hBB
`define VAC_RST_CURSOR 8'h0B
`define VAC_RST_BLINK 8'hFC
`define VAC_RST_GFX_ROWS 8'h48

`endif

// file: rtl/vac_chargen.v
// Attribute insertion, character generator and dot shifter of the video path
// Operation
// - Eight attributes, each active when bit low
// - Attribute source bit picks latches or external
// - Byte bit seven selects latch zero/one
// - Each latch written separately by software
// - External mode needs sixteen-bit bus too
// - Reverse video inverts the whole cell
// - Half intensity pin low, intensity mode
// - Blink character or field, per control bit
// - Double height steps glyph lines half rate
// - Blank plus double height shows lower half
// - Double height ignored on block graphics
// - Double width halves dots, skips next cell
// - Underline forces dots over its range
// - Blank suppresses character, memory untouched
// - Graphics attribute routes byte to blocks
// - Generator holds 128 glyphs 7x11
// - First line and column carry no glyph dots
// - Dots beyond glyph matrix are blank
// - Scan counter wraps; unreached compares inert
// - Scan lines counted from zero at top
// - Extent register: begin high, end low
// - Blink divider on frame rate, duty field
`timescale 1ns/10ps
`include "vac_defines.vh"

module vac_chargen #(
  parameter GLYPHS = 128,
  parameter GLYPH_W = 7,
  parameter GLYPH_H = 11
) (
  input wire clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire char_load,
  input wire [7:0] char_byte,
  input wire [7:0] char_attr,
  input wire cursor_here,
  input wire disp_active,
  input wire line_start,
  input wire frame_start,
  output reg video_out,
  output reg half_intensity_out_n
);

  localparam [10:0] GH = GLYPH_H;
  localparam [4:0] GW = GLYPH_W;

  reg [7:0] vcr_q;
  reg [7:0] scr_q;
  reg [7:0] latch0_q;
  reg [7:0] latch1_q;
  reg [3:0] cell_h_q;
  reg [3:0] cell_w_q;
  reg [7:0] ul_ext_q;
  reg [7:0] cur_ext_q;
  reg [7:0] blink_q;
  reg [7:0] gfx_rows_q;
  reg [6:0] g_code_q;
  reg [3:0] g_row_q;
  reg [GLYPH_W-1:0] glyph_mem [0:GLYPHS*GLYPH_H-1];

  reg [3:0] scan_q;
  reg ul_on_q;
  reg cur_on_q;
  reg [4:0] blk_cnt_q;
  reg [6:0] code_q;
  reg [7:0] attr_q;
  reg cursor_q;
  reg active_q;
  reg skip_q;
  reg [5:0] col_q;

  // Register port: glyph store access
  wire [10:0] wr_idx = {4'h0, g_code_q} * GH + {7'h00, g_row_q};
  wire [10:0] rd_idx;
  wire blink_on;
  wire [6:0] st_word = {blink_on, ul_on_q, cur_on_q, scan_q};

  always @(posedge clk) begin
    if (reg_wr && reg_addr == `VAC_OFF_GLYPH_DATA &&
        g_row_q < GH[3:0]) begin
      glyph_mem[wr_idx] <= reg_wdata[GLYPH_W-1:0];
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      vcr_q <= `VAC_RST_VCR;
      scr_q <= `VAC_RST_SCR;
      latch0_q <= `VAC_RST_LATCH;
      latch1_q <= `VAC_RST_LATCH;
      cell_h_q <= `VAC_RST_CELL_HEIGHT;
      cell_w_q <= `VAC_RST_CELL_WIDTH;
      ul_ext_q <= `VAC_RST_UNDERLINE;
      cur_ext_q <= `VAC_RST_CURSOR;
      blink_q <= `VAC_RST_BLINK;
      gfx_rows_q <= `VAC_RST_GFX_ROWS;
      g_code_q <= 7'h00;
      g_row_q <= 4'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `VAC_OFF_VIDEO_CTRL: vcr_q <= reg_wdata;
        `VAC_OFF_SYS_CTRL: scr_q <= reg_wdata;
        `VAC_OFF_LATCH_ZERO: latch0_q <= reg_wdata;
        `VAC_OFF_LATCH_ONE: latch1_q <= reg_wdata;
        `VAC_OFF_CELL_HEIGHT: cell_h_q <= reg_wdata[3:0];
        `VAC_OFF_CELL_WIDTH: cell_w_q <= reg_wdata[3:0];
        `VAC_OFF_UNDERLINE: ul_ext_q <= reg_wdata;
        `VAC_OFF_CURSOR: cur_ext_q <= reg_wdata;
        `VAC_OFF_BLINK: blink_q <= reg_wdata;
        `VAC_OFF_GFX_ROWS: gfx_rows_q <= reg_wdata;
        `VAC_OFF_GLYPH_CODE: g_code_q <= reg_wdata[6:0];
        `VAC_OFF_GLYPH_ROW: g_row_q <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  assign rd_idx = g_row_q < GH[3:0] ? wr_idx : 11'h000;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `VAC_OFF_VIDEO_CTRL: reg_rdata <= vcr_q;
        `VAC_OFF_SYS_CTRL: reg_rdata <= scr_q;
        `VAC_OFF_LATCH_ZERO: reg_rdata <= latch0_q;
        `VAC_OFF_LATCH_ONE: reg_rdata <= latch1_q;
        `VAC_OFF_CELL_HEIGHT: reg_rdata <= {4'h0, cell_h_q};
        `VAC_OFF_CELL_WIDTH: reg_rdata <= {4'h0, cell_w_q};
        `VAC_OFF_UNDERLINE: reg_rdata <= ul_ext_q;
        `VAC_OFF_CURSOR: reg_rdata <= cur_ext_q;
        `VAC_OFF_BLINK: reg_rdata <= blink_q;
        `VAC_OFF_GFX_ROWS: reg_rdata <= gfx_rows_q;
        `VAC_OFF_GLYPH_CODE: reg_rdata <= {1'b0, g_code_q};
        `VAC_OFF_GLYPH_ROW: reg_rdata <= {4'h0, g_row_q};
        `VAC_OFF_GLYPH_DATA: begin
          reg_rdata <= {{(8-GLYPH_W){1'b0}}, glyph_mem[rd_idx]};
        end
        `VAC_OFF_STATUS: reg_rdata <= {1'b0, st_word};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Scan line counter and underline / cursor flip-flops
  wire [3:0] scan_nx = (scan_q == cell_h_q) ? 4'h0 : scan_q + 4'h1;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_q <= 4'h0;
      ul_on_q <= 1'b0;
      cur_on_q <= 1'b0;
    end else if (frame_start) begin
      // top line of a cell is zero
      scan_q <= 4'h0;
      ul_on_q <= (ul_ext_q[7:4] == 4'h0);
      cur_on_q <= (cur_ext_q[7:4] == 4'h0);
    end else if (line_start) begin
      scan_q <= scan_nx;
      if (scan_nx == ul_ext_q[7:4]) begin
        ul_on_q <= 1'b1;
      end else if (scan_nx == ul_ext_q[3:0]) begin
        ul_on_q <= 1'b0;
      end
      if (scan_nx == cur_ext_q[7:4]) begin
        cur_on_q <= 1'b1;
      end else if (scan_nx == cur_ext_q[3:0]) begin
        cur_on_q <= 1'b0;
      end
    end
  end

  // Blink divider stepped once per frame
  wire [4:0] blk_rate = blink_q[7:3];
  wire [8:0] blk_lim = {6'h00, blink_q[2:0]} * ({4'h0, blk_rate} + 9'h001);
  assign blink_on = (blk_cnt_q == 5'h00) ||
                    ({1'b0, blk_cnt_q, 3'h0} < blk_lim);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      blk_cnt_q <= 5'h00;
    end else if (frame_start) begin
      blk_cnt_q <= (blk_cnt_q >= blk_rate) ? 5'h00 : blk_cnt_q + 5'h01;
    end
  end

  // Attribute source and cell latching
  // external needs both bus width and select
  wire ext_mode = vcr_q[`VAC_VCR_EXT_ATTR] & scr_q[`VAC_SCR_BUS16];
  // byte bit seven selects the latch
  wire [7:0] attr_in = ext_mode ? char_attr :
                       (char_byte[7] ? latch1_q : latch0_q);
  wire [5:0] width6 = {2'h0, cell_w_q} + 6'h01;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      code_q <= 7'h00;
      attr_q <= 8'hFF;
      cursor_q <= 1'b0;
      active_q <= 1'b0;
      skip_q <= 1'b0;
      col_q <= 6'h3F;
    end else if (line_start) begin
      active_q <= 1'b0;
      skip_q <= 1'b0;
      col_q <= 6'h3F;
    end else if (char_load && skip_q) begin
      skip_q <= 1'b0;
      col_q <= width6;
    end else if (char_load) begin
      code_q <= char_byte[6:0];
      attr_q <= attr_in;
      cursor_q <= cursor_here;
      active_q <= disp_active;
      skip_q <= ~attr_in[`VAC_AT_DWIDTH];
      col_q <= 6'h00;
    end else if (col_q != 6'h3F) begin
      col_q <= col_q + 6'h01;
    end
  end

  // attribute active when its bit is zero
  wire a_rev = ~attr_q[`VAC_AT_REVERSE];
  wire a_half = ~attr_q[`VAC_AT_HALF];
  wire a_blink = ~attr_q[`VAC_AT_BLINK];
  wire a_dh = ~attr_q[`VAC_AT_DHEIGHT];
  wire a_dw = ~attr_q[`VAC_AT_DWIDTH];
  wire a_ul = ~attr_q[`VAC_AT_UNDERLINE];
  wire a_blank = ~attr_q[`VAC_AT_BLANK];
  wire a_gfx = ~attr_q[`VAC_AT_GRAPHICS];

  // Glyph line, with double height stepping
  wire [4:0] scan5 = {1'b0, scan_q};
  wire [4:0] high5 = {1'b0, cell_h_q} + 5'h01;
  wire [4:0] dh_sum = (a_blank ? scan5 + high5 : scan5);
  wire [4:0] line5 = a_dh ? {1'b0, dh_sum[4:1]} : scan5;

  wire [5:0] dcol = a_dw ? {1'b0, col_q[5:1]} : col_q;

  // line zero and column zero stay blank
  wire in_rows = (line5 != 5'h00) && (line5 <= GH[4:0]);
  wire in_cols = (dcol != 6'h00) && (dcol <= {1'b0, GW});
  wire [3:0] g_line = line5[3:0] - 4'h1;
  wire [2:0] g_bit = dcol[2:0] - 3'h1;
  wire [10:0] show_idx = {4'h0, code_q} * GH + {7'h00, g_line};
  wire [GLYPH_W-1:0] g_word = glyph_mem[in_rows ? show_idx : 11'h000];
  wire glyph_dot = in_rows && in_cols && g_word[g_bit];

  // Block graphics: three rows by three columns, first dot is left
  wire [1:0] gr = (scan_q < gfx_rows_q[7:4]) ? 2'd0 :
                  (scan_q < gfx_rows_q[3:0]) ? 2'd1 : 2'd2;
  wire [1:0] gc = (col_q < 6'h03) ? 2'd0 :
                  (col_q + 6'h03 > width6) ? 2'd2 : 2'd1;
  reg gfx_dot;

  always @* begin
    case ({gr, gc})
      4'h0: gfx_dot = code_q[0];
      4'h1: gfx_dot = code_q[1];
      4'h2: gfx_dot = code_q[2];
      4'h4: gfx_dot = code_q[3];
      4'h5: gfx_dot = code_q[4];
      4'h6: gfx_dot = code_q[5];
      4'h8: gfx_dot = code_q[6];
      4'h9: gfx_dot = code_q[5];
      4'hA: gfx_dot = code_q[0];
      default: gfx_dot = 1'b0;
    endcase
  end

  // Dot composition
  reg dot;

  always @* begin
    dot = a_gfx ? gfx_dot : glyph_dot;
    // blank hides the dot, memory unchanged
    // double height is moot for block cells
    if (a_blank && !(a_dh && !a_gfx)) begin
      dot = 1'b0;
    end
    // character blink only hides the glyph
    if (a_blink && !blink_on && !vcr_q[`VAC_VCR_BLINK_FIELD]) begin
      dot = 1'b0;
    end
    if (a_ul && ul_on_q) begin
      dot = 1'b1;
    end
    if (cursor_q && cur_on_q) begin
      dot = ~dot;
    end
    if (a_rev) begin
      dot = ~dot;
    end
    // field blink flips the surrounding cell
    if (a_blink && !blink_on && vcr_q[`VAC_VCR_BLINK_FIELD]) begin
      dot = ~dot;
    end
    if (vcr_q[`VAC_VCR_SCREEN_REV]) begin
      dot = ~dot;
    end
    if (!active_q || col_q == 6'h3F) begin
      dot = 1'b0;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      video_out <= 1'b0;
      half_intensity_out_n <= 1'b1;
    end else begin
      video_out <= dot;
      // low while a half intensity cell shows
      half_intensity_out_n <= ~(a_half && active_q && col_q != 6'h3F &&
                                !scr_q[`VAC_SCR_PIN_CLOCK]);
    end
  end

endmodule
